// ===== logic/fnc_flash_host.sv
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module fnc_flash_host (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Software register port.
  input wire logic [4:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Flash pins.
  output fnc_pkg::fnc_pins_s flashPins,
  input wire logic [15:0] dqIn,
  input wire logic supplyLow
);
  typedef enum logic [3:0] {
    M_BOOT = 4'b0001,
    M_IDLE = 4'b0010,
    M_ISSUE = 4'b0100,
    M_WAIT = 4'b1000
  } fnc_main_e;

  fnc_main_e state, next_state;
  logic [11:0] bootCnt, next_bootCnt;
  logic [2:0] step, next_step;
  logic [3:0] op, next_op;
  logic [2:0] cfg, next_cfg;
  logic [18:0] userAddr, next_userAddr;
  logic [15:0] userData, next_userData;
  logic [15:0] rdata, next_rdata;
  logic refused, next_refused;
  logic eraseActive, next_eraseActive;
  logic chipErase, next_chipErase;
  logic suspended, next_suspended;
  logic cycStart, next_cycStart;
  fnc_pkg::fnc_cyc_s cycReq, next_cycReq;
  logic [31:0] next_regRdata;
  logic cycDone;
  logic [15:0] cycRd;
  logic cmdWr;
  logic [3:0] newOp;
  logic accept;

  fnc_bus_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(cycStart),
    .cyc(cycReq),
    .wordMode(cfg[fnc_pkg::CFG_WORD]),
    .hvReq(cfg[fnc_pkg::CFG_HV]),
    .restore(cfg[fnc_pkg::CFG_RESTORE]),
    .pins(flashPins),
    .done(cycDone),
    .rdData(cycRd),
    .dqIn(dqIn)
  );

  ////////////////////////////////////////////////////////////////////////////////
  assign cmdWr = regWr && (regAddr == fnc_pkg::REG_CMD);
  assign newOp = regWdata[3:0];

  // Refusals keep the flash out of states the device would silently ignore.
  always_comb begin
    accept = (state == M_IDLE) && (fnc_pkg::opSteps(newOp) != 3'd1 || newOp == fnc_pkg::OP_READ
      || newOp == fnc_pkg::OP_RESET || newOp == fnc_pkg::OP_SUSP
      || newOp == fnc_pkg::OP_RESUME);
    if (supplyLow && newOp != fnc_pkg::OP_READ) begin
      accept = 1'b0;
    end
    if (eraseActive && newOp != fnc_pkg::OP_READ && newOp != fnc_pkg::OP_SUSP) begin
      accept = 1'b0;
    end
    if (newOp == fnc_pkg::OP_SUSP && (!eraseActive || chipErase)) begin
      accept = 1'b0;
    end
    if (newOp == fnc_pkg::OP_RESUME && !suspended) begin
      accept = 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    next_bootCnt = bootCnt;
    next_step = step;
    next_op = op;
    next_cfg = cfg;
    next_userAddr = userAddr;
    next_userData = userData;
    next_rdata = rdata;
    next_refused = refused;
    next_eraseActive = eraseActive;
    next_chipErase = chipErase;
    next_suspended = suspended;
    next_cycStart = 1'b0;
    next_cycReq = cycReq;
    if (regWr) begin
      case (regAddr)
        // Protect and unprotect runs are software's: it protects all other sectors first.
        fnc_pkg::REG_CFG: next_cfg = regWdata[2:0];
        fnc_pkg::REG_ADDR: next_userAddr = regWdata[18:0];
        fnc_pkg::REG_WDATA: next_userData = regWdata[15:0];
        fnc_pkg::REG_STATUS: begin
          if (regWdata[fnc_pkg::ST_ERASE]) begin
            next_eraseActive = 1'b0;
            next_chipErase = 1'b0;
          end
        end
        default: ;
      endcase
    end
    case (state)
      M_BOOT: begin
        next_bootCnt = bootCnt - 12'h001;
        if (bootCnt == 12'h001) begin
          next_state = M_IDLE;
        end
        if (cmdWr) begin
          next_refused = 1'b1;
        end
      end
      M_IDLE: begin
        if (cmdWr) begin
          next_refused = ~accept;
          if (accept) begin
            next_op = newOp;
            next_step = 3'd0;
            next_state = M_ISSUE;
          end
        end
      end
      M_ISSUE: begin
        next_cycReq = fnc_pkg::stepCyc(op, step, userAddr, userData, cfg[fnc_pkg::CFG_WORD]);
        next_cycStart = 1'b1;
        next_state = M_WAIT;
      end
      M_WAIT: begin
        if (cycDone) begin
          if (!cycReq.isWrite) begin
            next_rdata = cycRd;
          end
          if (supplyLow && op != fnc_pkg::OP_READ) begin
            // The device resets under lockout, so the sequence is dropped.
            next_refused = 1'b1;
            next_eraseActive = 1'b0;
            next_chipErase = 1'b0;
            next_suspended = 1'b0;
            next_state = M_IDLE;
          end else if (step == fnc_pkg::opSteps(op) - 3'd1) begin
            next_state = M_IDLE;
            case (op)
              fnc_pkg::OP_CHIP, fnc_pkg::OP_SECT, fnc_pkg::OP_RESUME: begin
                next_eraseActive = 1'b1;
                next_chipErase = (op == fnc_pkg::OP_CHIP);
                next_suspended = 1'b0;
              end
              fnc_pkg::OP_SUSP: begin
                next_eraseActive = 1'b0;
                next_suspended = 1'b1;
              end
              default: ;
            endcase
          end else begin
            next_step = step + 3'd1;
            next_state = M_ISSUE;
          end
        end
      end
      default: next_state = M_IDLE;
    endcase
  end

  always_comb begin
    next_regRdata = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        fnc_pkg::REG_CFG: next_regRdata = {29'h0, cfg};
        fnc_pkg::REG_ADDR: next_regRdata = {13'h0, userAddr};
        fnc_pkg::REG_WDATA: next_regRdata = {16'h0, userData};
        fnc_pkg::REG_STATUS: next_regRdata = {26'h0, suspended, state == M_BOOT, supplyLow,
          eraseActive, refused, state != M_IDLE};
        fnc_pkg::REG_RDATA: next_regRdata = {16'h0, rdata};
        default: next_regRdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= M_BOOT;
      bootCnt <= 12'(fnc_pkg::BOOT_CYC);
      step <= 3'd0;
      op <= fnc_pkg::OP_READ;
      cfg <= fnc_pkg::CFG_RESET;
      userAddr <= 19'h00000;
      userData <= 16'h0000;
      rdata <= 16'h0000;
      refused <= 1'b0;
      eraseActive <= 1'b0;
      chipErase <= 1'b0;
      suspended <= 1'b0;
      cycStart <= 1'b0;
      cycReq <= '{isWrite: 1'b0, addr: 19'h00000, data: 16'h0000};
      regRdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      bootCnt <= next_bootCnt;
      step <= next_step;
      op <= next_op;
      cfg <= next_cfg;
      userAddr <= next_userAddr;
      userData <= next_userData;
      rdata <= next_rdata;
      refused <= next_refused;
      eraseActive <= next_eraseActive;
      chipErase <= next_chipErase;
      suspended <= next_suspended;
      cycStart <= next_cycStart;
      cycReq <= next_cycReq;
      regRdata <= next_regRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_unlock_first_word: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && fnc_pkg::isMulti(op) && step == 3'd0) |-> (cycReq.data == fnc_pkg::D_UNLOCK1
      ##2 !flashPins.weN))
    else $error("multi-cycle command did not open with the first unlock write");
  chk_unlock_second_word: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && fnc_pkg::isMulti(op) && step == 3'd1) |-> cycReq.data == fnc_pkg::D_UNLOCK2)
    else $error("second cycle of a command was not the second unlock");
  chk_program_setup: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && op == fnc_pkg::OP_PROG && step == 3'd3) |->
      (cycReq.addr == userAddr && cycReq.data == userData && $past(cycReq.data, 7)
       == fnc_pkg::D_PROG))
    else $error("program data write not preceded by the program setup value");
  chk_chip_final: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && op == fnc_pkg::OP_CHIP && step == 3'd5) |-> cycReq.data == fnc_pkg::D_CHIP)
    else $error("chip erase sixth cycle carried the wrong value");
  chk_sector_final: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && op == fnc_pkg::OP_SECT && step == 3'd5) |->
      (cycReq.data == fnc_pkg::D_SECTOR && cycReq.addr == userAddr))
    else $error("sector erase sixth cycle was not 30 at the sector address");
  chk_identify_cmd: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && op == fnc_pkg::OP_AUTOSEL && step == 3'd2) |->
      cycReq.data == fnc_pkg::D_AUTOSEL)
    else $error("identify sequence third cycle was not 90");
  chk_suspend_single: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && op == fnc_pkg::OP_SUSP) |-> (cycReq.data == fnc_pkg::D_SUSPEND
      && cycReq.isWrite && !chipErase))
    else $error("suspend issued with the wrong value or during chip erase");
  chk_verify_exit: assert property (@(posedge clk_sys) disable iff (rst)
    (cycStart && op == fnc_pkg::OP_VERIFY && step == 3'd4) |->
      (cycReq.data == fnc_pkg::D_RESET && $past(cycReq.isWrite, 7) == 1'b0))
    else $error("protect verify did not leave identify mode with a reset write");
  chk_hv_follows_cfg: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(cfg[fnc_pkg::CFG_HV]) |-> ##1 flashPins.hvReq)
    else $error("elevated restore level request did not follow its control bit");
endmodule

// ===== logic/fnc_pkg.sv
package fnc_pkg;
  // Clock and timing.
  localparam int CLK_NS = 20;
  localparam int T_GLITCH_NS = 5;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int T_BOOT_NS = 50000;
  localparam int GLITCH_CYC = (T_GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_RAW = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (WP_RAW > GLITCH_CYC) ? WP_RAW : GLITCH_CYC + 1;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BOOT_CYC = (T_BOOT_NS + CLK_NS - 1) / CLK_NS;

  // Software register offsets.
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_CFG = 5'h04;
  localparam logic [4:0] REG_ADDR = 5'h08;
  localparam logic [4:0] REG_WDATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam logic [4:0] REG_RDATA = 5'h14;

  // Field positions.
  localparam int CFG_WORD = 0;
  localparam int CFG_HV = 1;
  localparam int CFG_RESTORE = 2;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_ERASE = 2;
  localparam int ST_LOCKOUT = 3;
  localparam int ST_BOOT = 4;
  localparam int ST_SUSP = 5;
  localparam logic [2:0] CFG_RESET = 3'h1;

  // Command data values.
  localparam logic [15:0] D_UNLOCK1 = 16'h00AA;
  localparam logic [15:0] D_UNLOCK2 = 16'h0055;
  localparam logic [15:0] D_PROG = 16'h00A0;
  localparam logic [15:0] D_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] D_CHIP = 16'h0010;
  localparam logic [15:0] D_SECTOR = 16'h0030;
  localparam logic [15:0] D_AUTOSEL = 16'h0090;
  localparam logic [15:0] D_RESET = 16'h00F0;
  localparam logic [15:0] D_SUSPEND = 16'h00B0;
  localparam logic [15:0] D_RESUME = 16'h0030;

  // Command addresses, word and byte forms.
  localparam logic [18:0] A_W_UNLOCK1 = 19'h00555;
  localparam logic [18:0] A_W_UNLOCK2 = 19'h002AA;
  localparam logic [18:0] A_B_UNLOCK1 = 19'h00AAA;
  localparam logic [18:0] A_B_UNLOCK2 = 19'h00555;
  localparam logic [18:0] A_W_PROT_OFS = 19'h00002;
  localparam logic [18:0] A_B_PROT_OFS = 19'h00004;
  localparam logic [18:0] A_W_SECT_MASK = 19'h3F000;
  localparam logic [18:0] A_B_SECT_MASK = 19'h7E000;

  typedef enum logic [3:0] {
    OP_READ = 4'h1,
    OP_RESET = 4'h2,
    OP_AUTOSEL = 4'h3,
    OP_PROG = 4'h4,
    OP_CHIP = 4'h5,
    OP_SECT = 4'h6,
    OP_SUSP = 4'h7,
    OP_RESUME = 4'h8,
    OP_VERIFY = 4'h9
  } fnc_op_e;

  typedef struct packed {
    logic [17:0] addr;
    logic [15:0] dqOut;
    logic [15:0] dqOe;
    logic ceN;
    logic oeN;
    logic weN;
    logic byteN;
    logic resetN;
    logic hvReq;
  } fnc_pins_s;

  typedef struct packed {
    logic isWrite;
    logic [18:0] addr;
    logic [15:0] data;
  } fnc_cyc_s;

  function automatic logic [2:0] opSteps(input logic [3:0] o);
    case (o)
      OP_AUTOSEL: opSteps = 3'd3;
      OP_PROG: opSteps = 3'd4;
      OP_VERIFY: opSteps = 3'd5;
      OP_CHIP, OP_SECT: opSteps = 3'd6;
      default: opSteps = 3'd1;
    endcase
  endfunction

  function automatic logic isMulti(input logic [3:0] o);
    isMulti = (opSteps(o) > 3'd1);
  endfunction

  // Builds cycle k of operation o from the software address ua and data ud.
  function automatic fnc_cyc_s stepCyc(input logic [3:0] o, input logic [2:0] k,
      input logic [18:0] ua, input logic [15:0] ud, input logic wm);
    fnc_cyc_s c;
    logic [18:0] u1;
    logic [18:0] u2;
    u1 = wm ? A_W_UNLOCK1 : A_B_UNLOCK1;
    u2 = wm ? A_W_UNLOCK2 : A_B_UNLOCK2;
    c.isWrite = 1'b1;
    c.addr = u1;
    c.data = D_UNLOCK1;
    if (!isMulti(o)) begin
      c.addr = ua;
      case (o)
        OP_READ: c.isWrite = 1'b0;
        OP_SUSP: c.data = D_SUSPEND;
        OP_RESUME: c.data = D_RESUME;
        default: c.data = D_RESET;
      endcase
    end else begin
      case (k)
        3'd1, 3'd4: begin
          c.addr = u2;
          c.data = D_UNLOCK2;
          if (o == OP_VERIFY && k == 3'd4) begin
            // Identify mode ends on an explicit reset write, or on reset or lockout, never on its own.
            c.addr = ua;
            c.data = D_RESET;
          end
        end
        3'd2: begin
          case (o)
            OP_PROG: c.data = D_PROG;
            OP_CHIP, OP_SECT: c.data = D_ERASE_SETUP;
            default: c.data = D_AUTOSEL;
          endcase
        end
        3'd3: begin
          if (o == OP_PROG) begin
            c.addr = ua;
            c.data = ud;
          end else if (o == OP_VERIFY) begin
            c.isWrite = 1'b0;
            c.addr = wm ? ((ua & A_W_SECT_MASK) | A_W_PROT_OFS)
                        : ((ua & A_B_SECT_MASK) | A_B_PROT_OFS);
          end
        end
        3'd5: begin
          if (o == OP_SECT) begin
            c.addr = ua;
            c.data = D_SECTOR;
          end else begin
            c.data = D_CHIP;
          end
        end
        default: c.data = D_UNLOCK1;
      endcase
    end
    return c;
  endfunction
endpackage

// ===== logic/fnc_bus_cycle.sv
`timescale 1ns/1ps
module fnc_bus_cycle (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Cycle request, pin outputs and completion.
  input wire logic start,
  input wire fnc_pkg::fnc_cyc_s cyc,
  input wire logic wordMode,
  input wire logic hvReq,
  input wire logic restore,
  output fnc_pkg::fnc_pins_s pins,
  output logic done,
  output logic [15:0] rdData,
  // Flash data input.
  input wire logic [15:0] dqIn
);
  typedef enum logic [3:0] {
    BC_IDLE = 4'b0001,
    BC_SETUP = 4'b0010,
    BC_STROBE = 4'b0100,
    BC_HOLD = 4'b1000
  } fnc_bc_e;

  fnc_bc_e state, next_state;
  logic [7:0] cnt, next_cnt;
  fnc_pkg::fnc_pins_s next_pins;
  logic next_done;
  logic [15:0] next_rdData;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pins = pins;
    next_done = 1'b0;
    next_rdData = rdData;
    next_pins.byteN = wordMode;
    next_pins.hvReq = hvReq;
    next_pins.resetN = ~restore;
    case (state)
      BC_IDLE: begin
        if (start) begin
          // Address and data settle a full cycle before the write strobe falls; reads drop chip select and output gate with the address.
          next_pins.addr = wordMode ? cyc.addr[17:0] : cyc.addr[18:1];
          next_pins.dqOut = wordMode ? cyc.data : {cyc.addr[0], 7'h00, cyc.data[7:0]};
          if (wordMode) begin
            next_pins.dqOe = cyc.isWrite ? 16'hFFFF : 16'h0000;
          end else begin
            next_pins.dqOe = cyc.isWrite ? 16'h80FF : 16'h8000;
          end
          next_pins.oeN = 1'b1;
          next_state = cyc.isWrite ? BC_SETUP : BC_STROBE;
          next_cnt = cyc.isWrite ? 8'(fnc_pkg::WP_CYC) : 8'(fnc_pkg::ACC_CYC);
          if (!cyc.isWrite) begin
            next_pins.ceN = 1'b0;
            next_pins.oeN = 1'b0;
          end
        end
      end
      BC_SETUP: begin
        next_pins.ceN = 1'b0;
        next_pins.weN = 1'b0;
        next_state = BC_STROBE;
      end
      BC_STROBE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          // Rising strobes latch the data; reads sample at the access time.
          if (pins.oeN == 1'b0) begin
            next_rdData = wordMode ? dqIn : {8'h00, dqIn[7:0]};
          end
          next_pins.ceN = 1'b1;
          next_pins.weN = 1'b1;
          next_pins.oeN = 1'b1;
          next_state = BC_HOLD;
        end
      end
      BC_HOLD: begin
        next_pins.dqOe = wordMode ? 16'h0000 : 16'h8000;
        next_done = 1'b1;
        next_state = BC_IDLE;
      end
      default: next_state = BC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= BC_IDLE;
      cnt <= 8'h00;
      pins <= '{addr: 18'h00000, dqOut: 16'h0000, dqOe: 16'h0000, ceN: 1'b1, oeN: 1'b1,
                weN: 1'b1, byteN: 1'b1, resetN: 1'b1, hvReq: 1'b0};
      done <= 1'b0;
      rdData <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
      done <= next_done;
      rdData <= next_rdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_write_pin_combo: assert property (@(posedge clk_sys) disable iff (rst)
    !pins.weN |-> (!pins.ceN && pins.oeN && pins.dqOe[0]))
    else $error("write strobe low without chip select low and output gate high");
  chk_write_strobe_width: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(pins.weN) |-> (!pins.weN && !pins.ceN) [*2])
    else $error("write strobe pulse shorter than the glitch filter allows");
  chk_addr_held_strobe: assert property (@(posedge clk_sys) disable iff (rst)
    (!pins.ceN && !$past(pins.ceN)) |-> ($stable(pins.addr) && $stable(pins.dqOut)))
    else $error("address or data moved while chip select was low");
endmodule

// ===== testbench/fnc_flash_model.sv
`timescale 1ns/1ps
module fnc_flash_model #(
  parameter logic [63:0] PROT = 64'h0000000000000004,
  parameter logic [15:0] MAKER = 16'h005A, // Arbitrary value.
  parameter logic [15:0] PART = 16'h00C3, // Arbitrary value.
  parameter int ERASE_CYC = 100
) (
  // Clock and power-up.
  input wire logic clk_sys,
  input wire logic rst,
  // Host side pins.
  input wire fnc_pkg::fnc_pins_s pins,
  input wire logic supplyLow,
  output logic [15:0] dqIn
);
  logic [15:0] mem [logic [17:0]];
  fnc_pkg::fnc_pins_s prevP;
  logic [15:0] lastQ = 16'h0000;
  logic [17:0] a;
  logic [15:0] d;
  logic [2:0] st;
  logic er, idMode, erasing, susp;
  int eraseCnt;

  function automatic logic locked(input logic [17:0] x);
    return PROT[x[17:12]] && !pins.hvReq;
  endfunction

  // Collect first, then delete, so the map is not changed while it is walked.
  task automatic wipe(input logic [17:0] x, input bit all);
    logic [17:0] ks [$];
    foreach (mem[k]) if ((all || k[17:12] == x[17:12]) && !locked(k)) ks.push_back(k);
    foreach (ks[i]) mem.delete(ks[i]);
    erasing = 1'b1;
    eraseCnt = 0;
    st = 3'h0;
    er = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    a = prevP.addr;
    d = prevP.byteN ? prevP.dqOut : {8'h00, prevP.dqOut[7:0]};
    if (erasing && !susp) begin
      eraseCnt = eraseCnt + 1;
      if (eraseCnt == ERASE_CYC) erasing = 1'b0;
    end
    if (rst || supplyLow) begin
      st = 3'h0;
      er = 1'b0;
      idMode = 1'b0;
      erasing = 1'b0;
      susp = 1'b0;
    end else if (!prevP.weN && !prevP.ceN && prevP.oeN && (pins.weN || pins.ceN)) begin
      if (erasing && !susp) begin
        susp = (d == 16'h00B0);
      end else if (st == 3'h3) begin
        if (!locked(a)) mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
        st = 3'h0;
      end else if (st == 3'h0 && a == 18'h00555 && d == 16'h00AA) begin
        st = 3'h1;
      end else if (st == 3'h1 && a == 18'h002AA && d == 16'h0055) begin
        st = 3'h2;
      end else if (st == 3'h2 && er && d == 16'h0030) begin
        wipe(a, 1'b0);
      end else if (st == 3'h2 && er && a == 18'h00555 && d == 16'h0010) begin
        wipe(a, 1'b1);
      end else if (st == 3'h2 && !er && a == 18'h00555 && d == 16'h0080) begin
        er = 1'b1;
        st = 3'h0;
      end else if (st == 3'h2 && !er && a == 18'h00555 && d == 16'h00A0) begin
        st = 3'h3;
      end else if (st == 3'h2 && !er && a == 18'h00555 && d == 16'h0090) begin
        idMode = 1'b1;
        st = 3'h0;
      end else begin
        if (d == 16'h00F0) idMode = 1'b0;
        if (d == 16'h0030) susp = 1'b0;
        st = 3'h0;
        er = 1'b0;
      end
    end
    // Sleep is invisible here: the value stays latched while the address holds.
    if (!pins.ceN && !pins.oeN) begin
      if (!idMode) begin
        lastQ = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
      end else begin
        case (pins.addr[11:0])
          12'h000: lastQ = MAKER;
          12'h001: lastQ = PART;
          12'h002: lastQ = {15'h0000, PROT[pins.addr[17:12]]};
          default: lastQ = 16'hFFFF;
        endcase
      end
    end
    // A released bus shows the inverse, so a stale sample never matches.
    dqIn <= (!pins.ceN && !pins.oeN) ? lastQ : ~lastQ;
    prevP <= pins;
  end
endmodule

// ===== testbench/fnc_flash_host_bench.sv
`timescale 1ns/1ps
module fnc_flash_host_bench;
  localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value.
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] regAddr = 5'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic supplyLow = 1'b0;
  logic [31:0] regRdata, got, eNote, mNote;
  logic [15:0] dqIn, pd;
  logic [17:0] pa, pb;
  fnc_pkg::fnc_pins_s flashPins;
  logic [31:0] expQ [$];
  logic [31:0] maskQ [$];
  logic rdPend = 1'b0;
  int errors = 0;
  int comparisons = 0;

  always #10 clk_sys = ~clk_sys;

  fnc_flash_host dut_u (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashPins(flashPins), .dqIn(dqIn),
    .supplyLow(supplyLow));
  fnc_flash_model #(.MAKER(MAKER), .ERASE_CYC(100)) model_u (.clk_sys(clk_sys), .rst(rst),
    .pins(flashPins), .supplyLow(supplyLow), .dqIn(dqIn));

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (rdPend) begin
      eNote = expQ.pop_front();
      mNote = maskQ.pop_front();
      if (mNote != 32'h0) begin
        comparisons++;
        if ((regRdata & mNote) !== eNote) begin
          errors++;
          $display("MISMATCH t=%0t read %h want %h", $time, regRdata, eNote);
        end
      end
    end
    rdPend <= regRd;
  end

  task automatic tally_and_finish();
    $display("counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    maskQ.push_back(m);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    got = regRdata;
    @(posedge clk_sys);
  endtask

  task automatic op(input fnc_pkg::fnc_op_e c, input logic [17:0] a, input logic [15:0] d);
    wr(fnc_pkg::REG_ADDR, {14'h0000, a});
    wr(fnc_pkg::REG_WDATA, {16'h0000, d});
    wr(fnc_pkg::REG_CMD, {28'h0000000, c});
    for (int i = 0; i < 100; i++) begin
      rd(fnc_pkg::REG_STATUS, 32'h0, 32'h0);
      if (got[fnc_pkg::ST_BUSY] === 1'b0) return;
    end
    errors++;
    $display("MISMATCH t=%0t busy never cleared", $time);
    tally_and_finish();
  endtask

  task automatic chk(input logic [17:0] a, input logic [15:0] e);
    op(fnc_pkg::OP_READ, a, 16'h0000);
    rd(fnc_pkg::REG_RDATA, {16'h0000, e}, 32'h0000FFFF);
  endtask

  task automatic settle();
    repeat (150) @(posedge clk_sys);
    wr(fnc_pkg::REG_STATUS, 32'h4);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(4650));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(fnc_pkg::REG_CFG, {29'h0, fnc_pkg::CFG_RESET}, 32'h7);
    rd(5'h18, 32'h0, 32'hFFFFFFFF);
    rd(fnc_pkg::REG_STATUS, 32'h10, 32'h10);
    wr(fnc_pkg::REG_CMD, 32'h4);
    rd(fnc_pkg::REG_STATUS, 32'h2, 32'h2);
    repeat (fnc_pkg::BOOT_CYC) @(posedge clk_sys);
    $display("test boot done");
    pa = {6'h01, 12'($urandom)};
    pb = {6'h02, 12'($urandom)};
    pd = 16'($urandom);
    op(fnc_pkg::OP_PROG, pa, pd);
    chk(pa, pd);
    op(fnc_pkg::OP_PROG, pb, pd);
    chk(pb, 16'hFFFF);
    wr(fnc_pkg::REG_CFG, 32'h3);
    op(fnc_pkg::OP_PROG, pb, pd);
    wr(fnc_pkg::REG_CFG, 32'h1);
    chk(pb, pd);
    op(fnc_pkg::OP_PROG, pb ^ 18'h00001, 16'h0000);
    chk(pb ^ 18'h00001, 16'hFFFF);
    $display("test protection done");
    op(fnc_pkg::OP_VERIFY, pb, 16'h0000);
    rd(fnc_pkg::REG_RDATA, 32'h1, 32'hFFFF);
    op(fnc_pkg::OP_VERIFY, pa, 16'h0000);
    rd(fnc_pkg::REG_RDATA, 32'h0, 32'hFFFF);
    op(fnc_pkg::OP_AUTOSEL, 18'h0, 16'h0000);
    chk(18'h0, MAKER);
    chk(18'h0, MAKER);
    op(fnc_pkg::OP_RESET, 18'h0, 16'h0000);
    chk(pa, pd);
    $display("test identify done");
    op(fnc_pkg::OP_SECT, {6'h01, 12'h000}, 16'h0000);
    rd(fnc_pkg::REG_STATUS, 32'h4, 32'h4);
    op(fnc_pkg::OP_PROG, pa, 16'h0000);
    rd(fnc_pkg::REG_STATUS, 32'h2, 32'h2);
    op(fnc_pkg::OP_SUSP, 18'h0, 16'h0000);
    rd(fnc_pkg::REG_STATUS, 32'h20, 32'h20);
    op(fnc_pkg::OP_RESUME, 18'h0, 16'h0000);
    rd(fnc_pkg::REG_STATUS, 32'h0, 32'h20);
    settle();
    chk(pa, 16'hFFFF);
    $display("test sector erase done");
    op(fnc_pkg::OP_PROG, {6'h03, 12'h00F}, pd);
    op(fnc_pkg::OP_CHIP, 18'h0, 16'h0000);
    settle();
    chk({6'h03, 12'h00F}, 16'hFFFF);
    chk(pb, pd);
    $display("test chip erase done");
    wr(fnc_pkg::REG_CFG, 32'h0);
    op(fnc_pkg::OP_PROG, 18'h06140, pd);
    chk(18'h06140, {8'h00, pd[7:0]});
    wr(fnc_pkg::REG_CFG, 32'h1);
    $display("test byte mode done");
    supplyLow <= 1'b1;
    @(posedge clk_sys);
    op(fnc_pkg::OP_PROG, pa, 16'h0000);
    rd(fnc_pkg::REG_STATUS, 32'hA, 32'hA);
    supplyLow <= 1'b0;
    @(posedge clk_sys);
    chk(pa, 16'hFFFF);
    wr(fnc_pkg::REG_CMD, 32'h4);
    supplyLow <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rd(fnc_pkg::REG_STATUS, 32'hA, 32'hF);
    supplyLow <= 1'b0;
    @(posedge clk_sys);
    $display("test lockout done");
    tally_and_finish();
  end
endmodule
